// ==== qddc_defines.vh ====
// constants shared by the downconverter and decimation path
`ifndef QDDC_DEFINES_VH
`define QDDC_DEFINES_VH

// decimation selection codes
`define DEC_SEL_32 3'h1
`define DEC_SEL_24 3'h2
`define DEC_SEL_16 3'h3
`define DEC_SEL_12 3'h4

// oscillator widths and moduli
`define COARSE_PH_W 6
`define COARSE_SCALE 64
`define FINE_PH_W 12
`define FINE_START_W 10
`define FINE_MOD_3 12'hc00
`define FINE_MOD_4 13'h1000
`define FINE_IDX_MUL 11'h555
`define FINE_IDX_LSB 16
`define FINE_IDX_4_LSB 6

// tuning word arithmetic on a 16-bit ratio fraction
`define RATIO_W 16
`define COARSE_LSB 10
`define COARSE_HALF 17'h0_200
`define FINE4_SHIFT 4
`define FINE4_HALF 18'h0_0008
`define FINE3_SHIFT 6
`define FINE3_HALF 20'h0_0020

// quarter-wave table geometry and data scaling
`define QUARTER 5'h10
`define QUARTER_PH 6'h10
`define FINE_MIX_SHIFT 7
`define HB_SHIFT 2
`define OUT_LSB 2

`endif

// ==== stream_fifo.v ====
// synchronous show-ahead fifo with valid/ready on both sides
`timescale 1ns/10ps
module stream_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire do_wr;
    wire do_rd;
    wire full;
    wire empty;

    // pointer compare with wrap bit
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign do_wr = in_valid & ~full;
    assign do_rd = out_ready & ~empty;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    // storage write
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule // stream_fifo

// ==== qddc_nco_decimation_path.v ====
// coarse and fine quadrature downconverter with fir decimation chain
//
// Behaviour
// - coarse mixer first, fine mixer after stage one
// - coarse oscillator 6 bits, fine 12 bits
// - combined step converter rate over 3072/4096
// - device computes both tuning words at init
// - coarse word is round(64 times ratio)
// - fine word rounds modulus times residual ratio
// - modulus 3072 for select 2,4 else 4096
// - sysref loads programmable start phases
// - coarse start phase step is 1/64 cycle
// - fine start phase step is 1/1024 cycle
// - overall decimation 12, 16, 24 or 32
// - matched i and q filter chains
// - first stage by three or by four
// - stages two and three each decimate two
// - fourth stage only for 24 and 32
// - symmetric coefficients give linear phase
// - fixed latency for every selection
// - select 1=32, 2=24, 3=16, 4=12
`timescale 1ns/10ps
`include "qddc_defines.vh"
module qddc_nco_decimation_path #(
    parameter DATA_W = 16,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // converter samples
    input wire [4:0] adc_data,
    input wire adc_valid,
    output wire adc_ready,
    // configuration
    input wire [2:0] decimation_select,
    input wire [`RATIO_W-1:0] if_ratio,
    input wire init_start,
    input wire [`COARSE_PH_W-1:0] coarse_nco_start_phase,
    input wire [`FINE_START_W-1:0] fine_nco_start_phase,
    input wire sysref,
    // status
    output reg [`COARSE_PH_W-1:0] coarse_nco_tuning_word,
    output reg [7:0] fine_nco_tuning_word,
    output reg sync_done,
    // complex output stream
    output wire out_valid,
    input wire out_ready,
    output wire [DATA_W-1:0] out_i,
    output wire [DATA_W-1:0] out_q
);

    localparam W = 18;

    // ************************************************
    // ** helper functions
    // ************************************************

    // quarter-wave sine, 127 full scale, index 0..16
    function [7:0] qsin;
        input [4:0] k;
        begin
            case (k)
                5'h00: qsin = 8'h00;
                5'h01: qsin = 8'h0c;
                5'h02: qsin = 8'h19;
                5'h03: qsin = 8'h25;
                5'h04: qsin = 8'h31;
                5'h05: qsin = 8'h3c;
                5'h06: qsin = 8'h47;
                5'h07: qsin = 8'h51;
                5'h08: qsin = 8'h5a;
                5'h09: qsin = 8'h62;
                5'h0a: qsin = 8'h6a;
                5'h0b: qsin = 8'h70;
                5'h0c: qsin = 8'h75;
                5'h0d: qsin = 8'h7a;
                5'h0e: qsin = 8'h7d;
                5'h0f: qsin = 8'h7e;
                default: qsin = 8'h7f;
            endcase
        end
    endfunction

    // full-cycle sine over 64 phase steps
    function signed [7:0] sin64;
        input [5:0] idx;
        reg [7:0] mag;
        begin
            mag = idx[4] ? qsin(`QUARTER - {1'b0, idx[3:0]}) : qsin({1'b0, idx[3:0]});
            sin64 = idx[5] ? -$signed(mag) : $signed(mag);
        end
    endfunction

    // decimation select decode: true when first stage divides by three
    function by_three;
        input [2:0] sel;
        begin
            by_three = (sel == `DEC_SEL_24) || (sel == `DEC_SEL_12);
        end
    endfunction

    // decimation select decode: true when fourth stage is in the path
    function use_stage4;
        input [2:0] sel;
        begin
            use_stage4 = (sel == `DEC_SEL_32) || (sel == `DEC_SEL_24);
        end
    endfunction

    // ************************************************
    // ** sysref synchroniser and edge
    // ************************************************

    reg sysref_meta_reg;
    reg sysref_sync_reg;
    reg sysref_last_reg;
    wire sync_pulse;

    // two flops then edge detect
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sysref_meta_reg <= 1'b0;
            sysref_sync_reg <= 1'b0;
            sysref_last_reg <= 1'b0;
        end else begin
            sysref_meta_reg <= sysref;
            sysref_sync_reg <= sysref_meta_reg;
            sysref_last_reg <= sysref_sync_reg;
        end
    end
    assign sync_pulse = sysref_sync_reg & ~sysref_last_reg;

    wire sel3 = by_three(decimation_select);
    wire sel_s4 = use_stage4(decimation_select);
    wire [12:0] fine_mod = sel3 ? {1'b0, `FINE_MOD_3} : `FINE_MOD_4;

    // ************************************************
    // ** tuning word computation
    // ************************************************

    wire [16:0] coarse_sum = {1'b0, if_ratio} + `COARSE_HALF;
    wire [6:0] coarse_full = coarse_sum[16:`COARSE_LSB];
    wire signed [17:0] resid = $signed({2'b00, if_ratio}) - $signed({1'b0, coarse_full, 10'h000});
    wire signed [17:0] fine4 = (resid + $signed(`FINE4_HALF)) >>> `FINE4_SHIFT;
    wire signed [19:0] resid3 = $signed({resid, 2'b00}) - $signed({{2{resid[17]}}, resid});
    wire signed [19:0] fine3 = (resid3 + $signed(`FINE3_HALF)) >>> `FINE3_SHIFT;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coarse_nco_tuning_word <= 6'h00;
            fine_nco_tuning_word <= 8'h00;
        end else if (init_start) begin
            coarse_nco_tuning_word <= coarse_full[5:0];
            fine_nco_tuning_word <= sel3 ? fine3[7:0] : fine4[7:0];
        end
    end

    // ************************************************
    // ** coarse oscillator and mixer
    // ************************************************

    wire s0 = adc_valid & adc_ready;
    reg [`COARSE_PH_W-1:0] cph_reg;
    reg signed [12:0] cm_i_reg;
    reg signed [12:0] cm_q_reg;
    reg cm_v_reg;
    wire signed [4:0] x = adc_data;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cph_reg <= 6'h00;
            cm_i_reg <= 13'h0000;
            cm_q_reg <= 13'h0000;
            cm_v_reg <= 1'b0;
        end else begin
            cm_v_reg <= s0 & ~sync_pulse;
            if (sync_pulse) begin
                cph_reg <= coarse_nco_start_phase;
            end else if (s0) begin
                cph_reg <= cph_reg + coarse_nco_tuning_word;
                cm_i_reg <= x * sin64(cph_reg + `QUARTER_PH);
                cm_q_reg <= -(x * sin64(cph_reg));
            end
        end
    end

    // ************************************************
    // ** first stage: boxcar by three or four
    // ************************************************

    reg [1:0] s1_cnt_reg;
    reg signed [15:0] acc_i_reg;
    reg signed [15:0] acc_q_reg;
    reg signed [15:0] s1_i_reg;
    reg signed [15:0] s1_q_reg;
    reg s1_v_reg;
    wire [1:0] s1_last = sel3 ? 2'h2 : 2'h3;
    wire signed [15:0] sum_i = acc_i_reg + cm_i_reg;
    wire signed [15:0] sum_q = acc_q_reg + cm_q_reg;

    // dump every three or four samples
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_cnt_reg <= 2'h0;
            acc_i_reg <= 16'h0000;
            acc_q_reg <= 16'h0000;
            s1_i_reg <= 16'h0000;
            s1_q_reg <= 16'h0000;
            s1_v_reg <= 1'b0;
        end else begin
            s1_v_reg <= 1'b0;
            if (sync_pulse) begin
                s1_cnt_reg <= 2'h0;
                acc_i_reg <= 16'h0000;
                acc_q_reg <= 16'h0000;
            end else if (cm_v_reg) begin
                if (s1_cnt_reg == s1_last) begin
                    s1_cnt_reg <= 2'h0;
                    acc_i_reg <= 16'h0000;
                    acc_q_reg <= 16'h0000;
                    s1_i_reg <= sum_i;
                    s1_q_reg <= sum_q;
                    s1_v_reg <= 1'b1;
                end else begin
                    s1_cnt_reg <= s1_cnt_reg + 1'b1;
                    acc_i_reg <= sum_i;
                    acc_q_reg <= sum_q;
                end
            end
        end
    end

    // ************************************************
    // ** fine oscillator and complex mixer
    // ************************************************

    reg [`FINE_PH_W-1:0] fph_reg;
    reg signed [W-1:0] fm_i_reg;
    reg signed [W-1:0] fm_q_reg;
    reg fm_v_reg;
    wire signed [13:0] fstep = $signed({2'b00, fph_reg}) + $signed({{6{fine_nco_tuning_word[7]}}, fine_nco_tuning_word});
    wire signed [13:0] fmod_s = $signed({1'b0, fine_mod});
    wire signed [13:0] fwrap = fstep[13] ? fstep + fmod_s : ((fstep >= fmod_s) ? fstep - fmod_s : fstep);
    // 1/1024 steps scaled to the modulus
    wire [11:0] fstart = sel3 ? ({1'b0, fine_nco_start_phase, 1'b0} + {2'b00, fine_nco_start_phase})
                              : {fine_nco_start_phase, 2'b00};
    wire [22:0] fidx_prod = fph_reg * `FINE_IDX_MUL;
    wire [5:0] fidx = sel3 ? fidx_prod[21:`FINE_IDX_LSB] : fph_reg[11:`FINE_IDX_4_LSB];
    wire signed [7:0] fcos = sin64(fidx + `QUARTER_PH);
    wire signed [7:0] fsin = sin64(fidx);
    wire signed [24:0] fmi = s1_i_reg * fcos + s1_q_reg * fsin;
    wire signed [24:0] fmq = s1_q_reg * fcos - s1_i_reg * fsin;
    wire signed [24:0] fmi_s = fmi >>> `FINE_MIX_SHIFT;
    wire signed [24:0] fmq_s = fmq >>> `FINE_MIX_SHIFT;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fph_reg <= 12'h000;
            fm_i_reg <= 18'h0_0000;
            fm_q_reg <= 18'h0_0000;
            fm_v_reg <= 1'b0;
        end else begin
            fm_v_reg <= s1_v_reg & ~sync_pulse;
            if (sync_pulse) begin
                fph_reg <= fstart;
            end else if (s1_v_reg) begin
                fph_reg <= fwrap[11:0];
                fm_i_reg <= fmi_s[W-1:0];
                fm_q_reg <= fmq_s[W-1:0];
            end
        end
    end

    // ************************************************
    // ** half-band style stages two to four
    // ************************************************

    wire signed [W-1:0] st_i [0:3];
    wire signed [W-1:0] st_q [0:3];
    wire st_v [0:3];
    assign st_i[0] = fm_i_reg;
    assign st_q[0] = fm_q_reg;
    assign st_v[0] = fm_v_reg;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : hb
            reg signed [W-1:0] d1_i_reg;
            reg signed [W-1:0] d2_i_reg;
            reg signed [W-1:0] d1_q_reg;
            reg signed [W-1:0] d2_q_reg;
            reg signed [W-1:0] y_i_reg;
            reg signed [W-1:0] y_q_reg;
            reg ph_reg;
            reg v_reg;
            wire signed [W+1:0] ti = st_i[g] + (d1_i_reg <<< 1) + d2_i_reg;
            wire signed [W+1:0] tq = st_q[g] + (d1_q_reg <<< 1) + d2_q_reg;
            wire signed [W+1:0] ti_s = ti >>> `HB_SHIFT;
            wire signed [W+1:0] tq_s = tq >>> `HB_SHIFT;
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    d1_i_reg <= {W{1'b0}};
                    d2_i_reg <= {W{1'b0}};
                    d1_q_reg <= {W{1'b0}};
                    d2_q_reg <= {W{1'b0}};
                    y_i_reg <= {W{1'b0}};
                    y_q_reg <= {W{1'b0}};
                    ph_reg <= 1'b0;
                    v_reg <= 1'b0;
                end else begin
                    v_reg <= 1'b0;
                    if (sync_pulse) begin
                        ph_reg <= 1'b0;
                    end else if (st_v[g]) begin
                        d1_i_reg <= st_i[g];
                        d2_i_reg <= d1_i_reg;
                        d1_q_reg <= st_q[g];
                        d2_q_reg <= d1_q_reg;
                        ph_reg <= ~ph_reg;
                        if (ph_reg) begin
                            y_i_reg <= ti_s[W-1:0];
                            y_q_reg <= tq_s[W-1:0];
                            v_reg <= 1'b1;
                        end
                    end
                end
            end
            assign st_i[g+1] = y_i_reg;
            assign st_q[g+1] = y_q_reg;
            assign st_v[g+1] = v_reg;
        end
    endgenerate

    // ************************************************
    // ** output selection and fifo
    // ************************************************

    wire fin_v = sel_s4 ? st_v[3] : st_v[2];
    wire signed [W-1:0] fin_i = sel_s4 ? st_i[3] : st_i[2];
    wire signed [W-1:0] fin_q = sel_s4 ? st_q[3] : st_q[2];

    // sync status held once phases are aligned
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_done <= 1'b0;
        end else if (sync_pulse) begin
            sync_done <= 1'b1;
        end
    end

    // one fifo word per decimated pair
    stream_fifo #(
        .WIDTH(2 * DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) out_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(fin_v),
        .in_ready(adc_ready),
        .in_data({fin_i[W-1:`OUT_LSB], fin_q[W-1:`OUT_LSB]}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data({out_i, out_q})
    );

endmodule // qddc_nco_decimation_path

// ==== qddc_path_checker_assertions.sv ====
// port-level assertions for the downconverter and decimation path
`timescale 1ns/10ps
`include "qddc_defines.vh"
module qddc_path_checker #(
    parameter DATA_W = 16
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // stream handshakes
    input wire adc_valid,
    input wire adc_ready,
    input wire out_valid,
    input wire out_ready,
    input wire [DATA_W-1:0] out_i,
    input wire [DATA_W-1:0] out_q,
    // configuration and status
    input wire [2:0] decimation_select,
    input wire [`RATIO_W-1:0] if_ratio,
    input wire init_start,
    input wire sysref,
    input wire [`COARSE_PH_W-1:0] coarse_nco_tuning_word,
    input wire [7:0] fine_nco_tuning_word,
    input wire sync_done
);
    logic [6:0] coarse_full;
    logic signed [19:0] resid;
    logic [7:0] fine_exp;
    logic [4:0] taken_cnt;

    // ********
    // reference tuning words
    // ********
    // rounded coarse word, then the residual scaled by the modulus
    always @* begin
        coarse_full = 7'(({1'b0, if_ratio} + 17'h0_0200) >> 10);
        resid = $signed({4'h0, if_ratio}) - $signed({3'h0, coarse_full, 10'h000});
        if (decimation_select == `DEC_SEL_24 || decimation_select == `DEC_SEL_12) begin
            fine_exp = 8'((3 * resid + 32) >>> 6);
        end else begin
            fine_exp = 8'((resid + 8) >>> 4);
        end
    end

    // saturating count of accepted samples since reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            taken_cnt <= 5'h00;
        end else if (adc_valid && adc_ready && taken_cnt != 5'h1f) begin
            taken_cnt <= taken_cnt + 5'h01;
        end
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_sysref_edge;
        !sysref ##1 sysref;
    endsequence
    sequence s_stalled;
        out_valid && !out_ready;
    endsequence

    property p_coarse_word;
        init_start |=> coarse_nco_tuning_word == 6'($past(coarse_full));
    endproperty
    a_coarse_word: assert property (p_coarse_word) else $error("coarse word wrong");
    property p_fine_word;
        init_start |=> fine_nco_tuning_word == $past(fine_exp);
    endproperty
    a_fine_word: assert property (p_fine_word) else $error("fine word wrong");
    property p_words_hold;
        !init_start |=> $stable(coarse_nco_tuning_word) && $stable(fine_nco_tuning_word);
    endproperty
    a_words_hold: assert property (p_words_hold) else $error("tuning word moved");
    property p_sync_edge;
        s_sysref_edge |-> ##[1:4] sync_done;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("sync not seen");
    property p_sync_sticky;
        sync_done |=> sync_done;
    endproperty
    a_sync_sticky: assert property (p_sync_sticky) else $error("sync dropped");
    property p_out_hold;
        s_stalled |=> out_valid && $stable(out_i) && $stable(out_q);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output changed while stalled");
    property p_full_data;
        !adc_ready |-> out_valid;
    endproperty
    a_full_data: assert property (p_full_data) else $error("refusing with empty buffer");
    property p_no_early;
        $rose(out_valid) |-> taken_cnt >= 5'h0c;
    endproperty
    a_no_early: assert property (p_no_early) else $error("output before a full group");
endmodule // qddc_path_checker

bind qddc_nco_decimation_path qddc_path_checker #(.DATA_W(DATA_W)) i_qddc_path_checker (
    .clk, .reset_n, .adc_valid, .adc_ready, .out_valid, .out_ready, .out_i, .out_q,
    .decimation_select, .if_ratio, .init_start, .sysref, .coarse_nco_tuning_word,
    .fine_nco_tuning_word, .sync_done);

// ==== iq_sink_model.sv ====
// far side model that drains the complex output stream
`timescale 1ns/10ps
module iq_sink_model (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // stream from the path
    input wire out_valid,
    input wire [15:0] out_i,
    input wire [15:0] out_q,
    output logic out_ready,
    // bench control and observation
    input wire stall,
    output logic [15:0] word_count,
    output logic [15:0] last_i,
    output logic [15:0] last_q
);
    // ready moves only after an edge; each taken pair is counted and kept
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ready <= 1'b0;
            word_count <= 16'h0000;
            last_i <= 16'h0000;
            last_q <= 16'h0000;
        end else begin
            out_ready <= !stall;
            if (out_valid && out_ready) begin
                word_count <= word_count + 16'h0001;
                last_i <= out_i;
                last_q <= out_q;
            end
        end
    end
endmodule // iq_sink_model

// ==== qddc_nco_decimation_path_test.sv ====
// self-checking bench for the downconverter and decimation path
`timescale 1ns/10ps
`include "qddc_defines.vh"
module qddc_nco_decimation_path_test;
    logic clk, reset_n, adc_valid, init_start, sysref, stall;
    logic [4:0] adc_data;
    logic [2:0] sel;
    logic [15:0] ratio;
    logic [5:0] cph;
    logic [9:0] fph;
    wire adc_ready, out_valid, out_ready, sync_done;
    wire [5:0] cw;
    wire [7:0] fw;
    wire [15:0] oi, oq, rx_count, rx_i, rx_q;
    int err_count, cmp_count;

    // ********
    // design and far side
    // ********
    qddc_nco_decimation_path i_qddc_nco_decimation_path (.clk(clk), .reset_n(reset_n),
        .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready), .decimation_select(sel),
        .if_ratio(ratio), .init_start(init_start), .coarse_nco_start_phase(cph),
        .fine_nco_start_phase(fph), .sysref(sysref), .coarse_nco_tuning_word(cw),
        .fine_nco_tuning_word(fw), .sync_done(sync_done), .out_valid(out_valid),
        .out_ready(out_ready), .out_i(oi), .out_q(oq));
    iq_sink_model i_iq_sink_model (.clk(clk), .reset_n(reset_n), .out_valid(out_valid), .out_i(oi),
        .out_q(oq), .out_ready(out_ready), .stall(stall), .word_count(rx_count), .last_i(rx_i),
        .last_q(rx_q));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ********
    // shared tasks
    // ********
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic limit(input int t);
        if (t > 2000) begin
            err_count++;
            $display("wait limit reached");
            complete_run;
        end
    endtask

    task automatic do_reset;
        reset_n <= 1'b0;
        tick(4);
        reset_n <= 1'b1;
        tick(1);
    endtask

    // deliver n accepted samples back to back
    task automatic send(input int n);
        int k, t;
        k = 0;
        t = 0;
        adc_valid <= 1'b1;
        while (k < n) begin
            @(negedge clk);
            if (adc_ready === 1'b1) k++;
            t++;
            limit(t);
            @(posedge clk);
        end
        adc_valid <= 1'b0;
    endtask

    // edges until a word is offered
    task automatic wait_out(output int lat);
        lat = 0;
        do begin
            @(posedge clk);
            #1;
            lat++;
            limit(lat);
        end while (out_valid !== 1'b1);
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset;
        chk("coarse word", 16'h0000, {10'h000, cw}); // cleared word
        chk("fine word", 16'h0000, {8'h00, fw}); // cleared word
        chk("sync", 16'h0000, {15'h0000, sync_done}); // not synced
        chk("out_valid", 16'h0000, {15'h0000, out_valid}); // nothing yet
        chk("adc_ready", 16'h0001, {15'h0000, adc_ready}); // room free
        $display("reset test done");
    endtask

    // back to back computations across all four codes
    task automatic t_tuning;
        logic [2:0] s[6] = '{3'h3, 3'h4, 3'h1, 3'h2, 3'h2, 3'h1};
        logic [15:0] r[6] = '{16'h0b33, 16'h0b33, 16'h0200, 16'h0200, 16'h01ff, 16'hffff};
        logic [5:0] ec[6] = '{6'h03, 6'h03, 6'h01, 6'h01, 6'h00, 6'h00};
        logic [7:0] ef[6] = '{8'hf3, 8'hf6, 8'he0, 8'he8, 8'h18, 8'h00};
        sel <= s[0];
        ratio <= r[0];
        init_start <= 1'b1;
        for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            if (j < 5) begin
                sel <= s[j + 1];
                ratio <= r[j + 1];
            end else begin
                init_start <= 1'b0;
            end
            #1;
            chk("coarse word", {10'h000, ec[j]}, {10'h000, cw}); // rounded ratio
            chk("fine word", {8'h00, ef[j]}, {8'h00, fw}); // modulus choice
        end
        $display("tuning test done");
    endtask

    // group size and delay for every decimation code
    task automatic t_decim;
        logic [2:0] m[5] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
        int d[5] = '{12, 16, 24, 32, 16};
        int lat[5];
        int l2;
        for (int j = 0; j < 5; j++) begin
            sel <= m[j];
            ratio <= 16'h0000;
            do_reset;
            send(d[j] - 1);
            tick(10);
            chk("early out_valid", 16'h0000, {15'h0000, out_valid}); // group size
            send(1);
            wait_out(lat[j]);
            tick(3);
            chk("q at dc", 16'h0000, rx_q); // zero sine
            chk("i positive", 16'h0001, {15'h0000, rx_i[15] == 1'b0 && rx_i != 16'h0000}); // in-phase path
            send(d[j]);
            wait_out(l2);
            chk("second delay", 16'(lat[j]), 16'(l2)); // fixed delay
        end
        chk("stage four delay 24", 16'(lat[0] + 1), 16'(lat[2])); // extra stage
        chk("stage four delay 32", 16'(lat[1] + 1), 16'(lat[3])); // extra stage
        chk("delay 12 vs 16", 16'(lat[0]), 16'(lat[1])); // same chain
        $display("decimation test done");
    endtask

    // fill the buffer with the far side stalled, then drain it
    task automatic t_fill;
        int t;
        sel <= `DEC_SEL_12;
        do_reset;
        stall <= 1'b1;
        adc_valid <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            @(negedge clk);
            t++;
            limit(t);
        end while (adc_ready === 1'b1);
        chk("out_valid when full", 16'h0001, {15'h0000, out_valid}); // data offered
        @(posedge clk);
        adc_valid <= 1'b0;
        stall <= 1'b0;
        t = 0;
        do begin
            @(negedge clk);
            t++;
            limit(t);
        end while (out_valid === 1'b1 || t < 4);
        chk("words drained", 16'h0010, rx_count); // one per group
        chk("ready after drain", 16'h0001, {15'h0000, adc_ready}); // room again
        $display("fill test done");
    endtask

    // quarter cycle start phases on either oscillator
    task automatic t_sync;
        logic [5:0] cp[2] = '{6'h10, 6'h00};
        logic [9:0] fp[2] = '{10'h000, 10'h100};
        int n;
        for (int j = 0; j < 2; j++) begin
            sel <= `DEC_SEL_16;
            cph <= cp[j];
            fph <= fp[j];
            do_reset;
            sysref <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (sync_done !== 1'b1 && n < 8);
            chk("sync delay", 16'h0001, {15'h0000, n <= 4}); // load on edge
            @(posedge clk);
            sysref <= 1'b0;
            tick(3);
            send(16);
            wait_out(n);
            tick(3);
            chk("i at quarter", 16'h0000, rx_i); // phase step
            chk("q sign", 16'h0001, {15'h0000, rx_q[15]}); // negative sine
        end
        $display("sync test done");
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        err_count = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        adc_valid = 1'b0;
        adc_data = 5'h0f;
        sel = `DEC_SEL_12;
        ratio = 16'h0000;
        init_start = 1'b0;
        cph = 6'h00;
        fph = 10'h000;
        sysref = 1'b0;
        stall = 1'b0;
        tick(4);
        reset_n <= 1'b1;
        tick(1);
        t_reset;
        t_tuning;
        t_decim;
        t_fill;
        t_sync;
        complete_run;
    end
endmodule // qddc_nco_decimation_path_test
